// [logic/swg_pkg.sv]
// Purpose: Shared constants and types of the switchgear object controller
// Assumes: 200 MHz hclk, 32-bit AHB-Lite register bus
// Notes: Register map, field positions, reset values and carrier structs
package swg_pkg;
  localparam int CLK_MHZ = 200;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRAV = 8'h04;
  localparam logic [7:0] OFS_PLEN = 8'h08;
  localparam logic [7:0] OFS_TMO = 8'h0c;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_NREQ = 8'h18;
  localparam logic [7:0] OFS_NFAIL = 8'h1c;
  localparam logic [7:0] OFS_MASK = 8'h20;
  localparam logic [7:0] OFS_USED = 8'h24;
  localparam logic [7:0] OFS_BSEL = 8'h28;
  localparam logic [7:0] OFS_LSEL = 8'h2c;
  localparam logic [7:0] OFS_LDATA = 8'h30;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CT_ENABLE = 0;
  localparam int CT_REMOTE = 1;
  localparam int CT_USE_SYNC = 2;
  localparam int CT_USE_READY = 3;
  localparam int CT_WITHDRAW = 4;
  localparam int CT_SG_FORCE = 5;
  localparam int CT_SG_REMOTE = 6;
  localparam int CT_SG_ENABLE = 7;
  localparam int CT_LATCH_LO = 8;
  localparam int CM_OPEN = 0;
  localparam int CM_CLOSE = 1;
  localparam int CM_CLR_STATS = 2;
  localparam int CM_CLR_LOG = 3;
  localparam int CM_CLR_LATCH = 4;
  localparam int CM_SG_REMOTE = 5;
  localparam int CM_SG_FORCE = 6;
  localparam int CM_SG_LO = 8;
  localparam int LOG_DEPTH = 12;
  // ---------------------------------------------------------------
  // Reset values and default times
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_USED = 32'h0000_0001;
  localparam int TRAV_US = 200000;
  localparam int PLEN_US = 200000;
  localparam int TMO_US = 1000000;
  localparam logic [31:0] TRAV_CYC = 32'(TRAV_US * CLK_MHZ);
  localparam logic [31:0] PLEN_CYC = 32'(PLEN_US * CLK_MHZ);
  localparam logic [31:0] TMO_CYC = 32'(TMO_US * CLK_MHZ);
  // Event codes
  localparam logic [2:0] EV_OPEN_REQ = 3'h0;
  localparam logic [2:0] EV_CLOSE_REQ = 3'h1;
  localparam logic [2:0] EV_OPEN_FAIL = 3'h2;
  localparam logic [2:0] EV_CLOSE_FAIL = 3'h3;
  localparam logic [2:0] EV_SG_CHANGE = 3'h4;
  localparam logic [2:0] EV_POS_CHANGE = 3'h5;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    POS_BAD = 2'b00, POS_CLOSED = 2'b01, POS_OPEN = 2'b10, POS_MID = 2'b11
  } pos_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_DRIVE = 2'b01, ST_WAIT = 2'b10
  } st_t;
  typedef struct packed {
    logic pos_open;
    logic pos_close;
    logic cart_in;
    logic cart_out;
    logic sync_ok;
    logic obj_ready;
    logic local_open;
    logic local_close;
    logic app_open;
    logic app_close;
    logic [7:0] block;
    logic [7:0] sg_pulse;
    logic [7:0] sg_level;
  } pins_t;
  typedef struct packed {
    logic open_cmd;
    logic close_cmd;
    logic [3:0] status;
    logic event_pulse;
    logic [2:0] event_code;
    logic [2:0] active_sg;
  } outs_t;
endpackage

// [logic/switchgear_object_controller.sv]
// Purpose: One switchgear object with setting group selection
// Assumes: Pins are asynchronous to hclk; AHB-Lite single word transfers
// Notes: Reads take one wait state, writes none; all outputs registered
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Position reported as bad, closed, open or intermediate from feedback.
// - Both feedback inputs low means intermediate, object in transit.
// - Both inputs high on object or cart means bad.
// - Intermediate shown only after traverse time passes without new position.
// - Open and close commands never longer than maximum pulse length.
// - Command drops at once when position feedback changes.
// - No position change within timeout aborts request, logs failure event.
// - Close refused unless every enabled sync and ready input is active.
// - Access local by default; local refuses bus, remote refuses local.
// - Application open and close obey no access selection.
// - Separate counters of open and close requests.
// - Separate failure counters when request leaves position unchanged.
// - Clear statistics zeroes request and failure counters.
// - Withdrawable object also uses cart inserted and withdrawn inputs.
// - Log keeps last 12 operations with time, type, failure; clearable.
// - Simultaneous group requests pick lowest index group.
// - Forced group change only while force enable set.
// - Only used groups may become active; one used after reset.
// - Groups selected by pulses or pulses mixed with levels.
// - Supervisory link group change only while remote enable set.
// - Event recorded only if its mask bit set; masks clear at reset.
// - Object and functions disabled after reset until enabled.
// - Any selected active blocking source inhibits operation.
// - Each status output latched or non-latched per connection.
// - Latched output holds until source drops and clear arrives.
module switchgear_object_controller #(
  parameter logic [31:0] TRAV_RST = swg_pkg::TRAV_CYC,
  parameter logic [31:0] PLEN_RST = swg_pkg::PLEN_CYC,
  parameter logic [31:0] TMO_RST = swg_pkg::TMO_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire swg_pkg::pins_t pins,
  output swg_pkg::outs_t outs
);
  typedef struct packed {
    swg_pkg::pins_t s1;
    swg_pkg::pins_t s2;
    swg_pkg::pins_t s3;
    logic [31:0] ctrl;
    logic [31:0] trav;
    logic [31:0] plen;
    logic [31:0] tmo;
    logic [7:0] mask;
    logic [7:0] used;
    logic [7:0] bsel;
    logic [3:0] lsel;
    swg_pkg::pos_t pos;
    logic [31:0] tcnt;
    swg_pkg::st_t st;
    logic is_close;
    swg_pkg::pos_t start;
    logic [31:0] pcnt;
    logic [31:0] wcnt;
    logic [15:0] n_open;
    logic [15:0] n_close;
    logic [15:0] f_open;
    logic [15:0] f_close;
    logic [swg_pkg::LOG_DEPTH-1:0][15:0] oplog;
    logic [3:0] wp;
    logic [3:0] lcnt;
    logic [3:0] held;
    logic rd_pend;
    logic wr_pend;
    logic [7:0] a;
    logic [31:0] rdata;
    logic rdy;
    swg_pkg::outs_t o;
  } state_t;

  state_t q;
  state_t next_q;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Feedback pair to position; both high is bad, both low in transit
  function automatic swg_pkg::pos_t decode(input logic op, input logic cl);
    case ({op, cl})
      2'b11: decode = swg_pkg::POS_BAD;
      2'b01: decode = swg_pkg::POS_CLOSED;
      2'b10: decode = swg_pkg::POS_OPEN;
      default: decode = swg_pkg::POS_MID;
    endcase
  endfunction

  // Lowest set bit: {found, index}; used for groups and events
  function automatic logic [3:0] first_set(input logic [7:0] v);
    first_set = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        first_set = {1'b1, 3'(i)};
      end
    end
  endfunction

  // Ring index of the k-th newest log entry
  function automatic logic [3:0] log_idx(input logic [3:0] wp,
                                         input logic [3:0] k);
    logic [4:0] t;
    t = 5'(wp) + 5'(swg_pkg::LOG_DEPTH) - 5'd1 - 5'(k);
    if (t >= 5'(swg_pkg::LOG_DEPTH)) begin
      t = t - 5'(swg_pkg::LOG_DEPTH);
    end
    log_idx = t[3:0];
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic av, req_open, req_close, blocked, close_ok, done, fail;
    logic [31:0] cmd;
    swg_pkg::pos_t raw, cart, obj;
    logic [7:0] sg_req;
    logic [3:0] pick, src;
    logic [2:0] grp;
    logic [7:0] ev;
    logic [15:0] entry;
    next_q = q;
    av = 1'b0;
    req_open = 1'b0;
    req_close = 1'b0;
    blocked = 1'b0;
    close_ok = 1'b0;
    done = 1'b0;
    fail = 1'b0;
    cmd = 32'h0000_0000;
    raw = swg_pkg::POS_MID;
    cart = swg_pkg::POS_MID;
    obj = swg_pkg::POS_MID;
    sg_req = 8'h00;
    pick = 4'h0;
    src = 4'h0;
    ev = 8'h00;
    entry = 16'h0000;
    grp = 3'h0;
    // Two-stage pin synchroniser, third stage for edge detection
    next_q.s1 = pins;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;

    // AHB-Lite slave: reads get one wait state so that a write
    // immediately before is always visible
    next_q.rdy = 1'b1;
    next_q.wr_pend = 1'b0;
    if (q.rd_pend) begin
      next_q.rd_pend = 1'b0;
      case (q.a)
        swg_pkg::OFS_CTRL: next_q.rdata = q.ctrl;
        swg_pkg::OFS_TRAV: next_q.rdata = q.trav;
        swg_pkg::OFS_PLEN: next_q.rdata = q.plen;
        swg_pkg::OFS_TMO: next_q.rdata = q.tmo;
        swg_pkg::OFS_STAT: next_q.rdata = {16'h0000, q.lcnt,
          1'b0, q.o.active_sg, q.o.open_cmd, q.o.close_cmd, q.st,
          2'b00, q.pos};
        swg_pkg::OFS_NREQ: next_q.rdata = {q.n_close, q.n_open};
        swg_pkg::OFS_NFAIL: next_q.rdata = {q.f_close, q.f_open};
        swg_pkg::OFS_MASK: next_q.rdata = {24'h00_0000, q.mask};
        swg_pkg::OFS_USED: next_q.rdata = {24'h00_0000, q.used};
        swg_pkg::OFS_BSEL: next_q.rdata = {24'h00_0000, q.bsel};
        swg_pkg::OFS_LSEL: next_q.rdata = {28'h000_0000, q.lsel};
        swg_pkg::OFS_LDATA: next_q.rdata = (q.lsel < q.lcnt) ?
          {16'h0000, q.oplog[log_idx(q.wp, q.lsel)]} : 32'h0000_0000;
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end
    if (hsel && htrans[1] && hready) begin
      next_q.a = {haddr[7:2], 2'b00};
      next_q.wr_pend = hwrite;
      next_q.rd_pend = !hwrite;
      next_q.rdy = hwrite;
    end
    // Write data phase
    if (q.wr_pend) begin
      case (q.a)
        swg_pkg::OFS_CTRL: next_q.ctrl = hwdata;
        swg_pkg::OFS_TRAV: next_q.trav = hwdata;
        swg_pkg::OFS_PLEN: next_q.plen = hwdata;
        swg_pkg::OFS_TMO: next_q.tmo = hwdata;
        swg_pkg::OFS_CMD: cmd = hwdata;
        swg_pkg::OFS_MASK: next_q.mask = hwdata[7:0];
        swg_pkg::OFS_USED: next_q.used = hwdata[7:0];
        swg_pkg::OFS_BSEL: next_q.bsel = hwdata[7:0];
        swg_pkg::OFS_LSEL: next_q.lsel = hwdata[3:0];
        default: av = 1'b0;
      endcase
    end

    // ---------------------------------------------------------------
    // Position with traverse filtering
    // ---------------------------------------------------------------
    raw = decode(q.s2.pos_open, q.s2.pos_close);
    cart = decode(q.s2.cart_out, q.s2.cart_in);
    obj = raw;
    if (q.ctrl[swg_pkg::CT_WITHDRAW] && cart == swg_pkg::POS_BAD) begin
      obj = swg_pkg::POS_BAD;
    end
    // Hold the last end position while in transit, so a normal
    // travel does not flash intermediate on the outputs
    if (obj == swg_pkg::POS_MID) begin
      if (q.tcnt >= q.trav) begin
        next_q.pos = swg_pkg::POS_MID;
      end else begin
        next_q.tcnt = q.tcnt + 32'd1;
      end
    end else begin
      next_q.tcnt = 32'h0000_0000;
      next_q.pos = obj;
    end
    if (next_q.pos != q.pos) begin
      ev[swg_pkg::EV_POS_CHANGE] = 1'b1;
    end

    // ---------------------------------------------------------------
    // Request sources, access and interlocks
    // ---------------------------------------------------------------
    req_open = q.s2.app_open && !q.s3.app_open;
    req_close = q.s2.app_close && !q.s3.app_close;
    if (q.ctrl[swg_pkg::CT_REMOTE]) begin
      req_open = req_open || cmd[swg_pkg::CM_OPEN];
      req_close = req_close || cmd[swg_pkg::CM_CLOSE];
    end else begin
      req_open = req_open || (q.s2.local_open && !q.s3.local_open);
      req_close = req_close ||
        (q.s2.local_close && !q.s3.local_close);
    end
    blocked = |(q.s2.block & q.bsel);
    close_ok = (!q.ctrl[swg_pkg::CT_USE_SYNC] || q.s2.sync_ok) &&
      (!q.ctrl[swg_pkg::CT_USE_READY] || q.s2.obj_ready);
    if (!q.ctrl[swg_pkg::CT_ENABLE] || blocked) begin
      req_open = 1'b0;
      req_close = 1'b0;
    end
    if (!close_ok || req_open) begin
      req_close = 1'b0;
    end

    // ---------------------------------------------------------------
    // Command sequencer
    // ---------------------------------------------------------------
    case (q.st)
      swg_pkg::ST_IDLE: begin
        // New request only from idle, open wins a tie
        if (req_open || req_close) begin
          next_q.st = swg_pkg::ST_DRIVE;
          next_q.is_close = req_close;
          next_q.start = raw;
          next_q.pcnt = 32'h0000_0000;
          next_q.wcnt = 32'h0000_0000;
          next_q.o.open_cmd = req_open;
          next_q.o.close_cmd = req_close;
          ev[swg_pkg::EV_OPEN_REQ] = req_open;
          ev[swg_pkg::EV_CLOSE_REQ] = req_close;
        end
      end
      swg_pkg::ST_DRIVE, swg_pkg::ST_WAIT: begin
        next_q.pcnt = q.pcnt + 32'd1;
        next_q.wcnt = q.wcnt + 32'd1;
        if (raw != q.start || q.pcnt + 32'd1 >= q.plen) begin
          next_q.o.open_cmd = 1'b0;
          next_q.o.close_cmd = 1'b0;
          next_q.st = swg_pkg::ST_WAIT;
        end
        if (raw == (q.is_close ? swg_pkg::POS_CLOSED :
                    swg_pkg::POS_OPEN)) begin
          done = 1'b1;
        end else if (q.wcnt + 32'd1 >= q.tmo) begin
          fail = 1'b1;
        end
        if (done || fail) begin
          next_q.st = swg_pkg::ST_IDLE;
          next_q.o.open_cmd = 1'b0;
          next_q.o.close_cmd = 1'b0;
          ev[swg_pkg::EV_OPEN_FAIL] = fail && !q.is_close;
          ev[swg_pkg::EV_CLOSE_FAIL] = fail && q.is_close;
        end
      end
      default: begin
        next_q.st = swg_pkg::ST_IDLE;
        next_q.o.open_cmd = 1'b0;
        next_q.o.close_cmd = 1'b0;
      end
    endcase

    // ---------------------------------------------------------------
    // Statistics: a count in the clearing cycle survives the clear
    // ---------------------------------------------------------------
    if (cmd[swg_pkg::CM_CLR_STATS]) begin
      next_q.n_open = 16'h0000;
      next_q.n_close = 16'h0000;
      next_q.f_open = 16'h0000;
      next_q.f_close = 16'h0000;
    end
    next_q.n_open = next_q.n_open + 16'(ev[swg_pkg::EV_OPEN_REQ]);
    next_q.n_close = next_q.n_close + 16'(ev[swg_pkg::EV_CLOSE_REQ]);
    next_q.f_open = next_q.f_open + 16'(ev[swg_pkg::EV_OPEN_FAIL]);
    next_q.f_close = next_q.f_close + 16'(ev[swg_pkg::EV_CLOSE_FAIL]);

    // Operation log; duration saturates at 14 bits of cycles
    if (cmd[swg_pkg::CM_CLR_LOG]) begin
      next_q.lcnt = 4'h0;
      next_q.wp = 4'h0;
    end
    if (done || fail) begin
      entry = {fail, q.is_close,
        (|q.wcnt[31:14]) ? 14'h3fff : q.wcnt[13:0]};
      next_q.oplog[next_q.wp] = entry;
      next_q.wp = (next_q.wp == 4'(swg_pkg::LOG_DEPTH - 1)) ?
        4'h0 : next_q.wp + 4'h1;
      if (next_q.lcnt != 4'(swg_pkg::LOG_DEPTH)) begin
        next_q.lcnt = next_q.lcnt + 4'h1;
      end
    end

    // ---------------------------------------------------------------
    // Setting groups: pulse edges and static levels, lowest wins
    // ---------------------------------------------------------------
    sg_req = (q.s2.sg_pulse & ~q.s3.sg_pulse) | q.s2.sg_level;
    pick = first_set(sg_req & q.used);
    if (pick[3] && q.ctrl[swg_pkg::CT_SG_ENABLE]) begin
      grp = pick[2:0];
      av = 1'b1;
    end
    if (cmd[swg_pkg::CM_SG_REMOTE] && q.ctrl[swg_pkg::CT_SG_REMOTE]) begin
      grp = cmd[swg_pkg::CM_SG_LO +: 3];
      av = 1'b1;
    end
    if (cmd[swg_pkg::CM_SG_FORCE] && q.ctrl[swg_pkg::CT_SG_FORCE]) begin
      grp = cmd[swg_pkg::CM_SG_LO +: 3];
      av = 1'b1;
    end
    if (av && q.used[grp] && grp != q.o.active_sg) begin
      next_q.o.active_sg = grp;
      ev[swg_pkg::EV_SG_CHANGE] = 1'b1;
    end

    // Masked event report, lowest code first
    pick = first_set(ev & q.mask);
    next_q.o.event_pulse = pick[3];
    if (pick[3]) begin
      next_q.o.event_code = pick[2:0];
    end

    // ---------------------------------------------------------------
    // Status outputs: closed, open, bad, intermediate
    // ---------------------------------------------------------------
    src = {next_q.pos == swg_pkg::POS_MID, next_q.pos == swg_pkg::POS_BAD,
      next_q.pos == swg_pkg::POS_OPEN, next_q.pos == swg_pkg::POS_CLOSED};
    for (int i = 0; i < 4; i++) begin
      // A clear while the source stands is ignored
      if (cmd[swg_pkg::CM_CLR_LATCH] && !src[i]) begin
        next_q.held[i] = 1'b0;
      end
      if (src[i]) begin
        next_q.held[i] = 1'b1;
      end
      next_q.o.status[i] = q.ctrl[swg_pkg::CT_LATCH_LO + i] ?
        next_q.held[i] : src[i];
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.ctrl <= swg_pkg::RST_CTRL;
      q.trav <= TRAV_RST;
      q.plen <= PLEN_RST;
      q.tmo <= TMO_RST;
      q.mask <= swg_pkg::RST_MASK[7:0];
      q.used <= swg_pkg::RST_USED[7:0];
      q.pos <= swg_pkg::POS_MID;
      q.start <= swg_pkg::POS_MID;
      q.st <= swg_pkg::ST_IDLE;
      q.rdy <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign hreadyout = q.rdy;
  assign hrdata = q.rdata;
  assign hresp = 1'b0;
  assign outs = q.o;
endmodule
`default_nettype wire

// [bench/swg_sva.sv]
// Purpose: Port checks of the switchgear object controller
// Assumes: Parameters equal those of the bench instance
// Notes: Sees only top module ports; bound after the module
`timescale 1ns/1ps
`default_nettype none
module swg_sva #(
  parameter logic [31:0] TRAV_RST = 32'h14,
  parameter logic [31:0] PLEN_RST = 32'h32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire swg_pkg::pins_t pins,
  input wire swg_pkg::outs_t outs
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------
  // Run lengths
  // ----------------------------------------------------------
  // Counters avoid long repetitions that tools would unroll
  logic [31:0] cmd_len, low_len;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_len <= '0;
      low_len <= '0;
    end else begin
      cmd_len <= (outs.open_cmd | outs.close_cmd) ? cmd_len + 1 : '0;
      low_len <= (pins.pos_open | pins.pos_close) ? '0 : low_len + 1;
    end
  end
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  both_cmds_a: assert property (
    !(outs.open_cmd && outs.close_cmd)) else $error("both commands");
  pulse_len_a: assert property (
    (outs.open_cmd || outs.close_cmd) |-> cmd_len < PLEN_RST)
    else $error("command pulse too long");
  cmd_cut_a: assert property (
    (outs.open_cmd || outs.close_cmd) &&
    $changed({pins.pos_open, pins.pos_close})
    |-> ##[1:4] !(outs.open_cmd || outs.close_cmd))
    else $error("command not cut on feedback change");
  bad_pos_a: assert property (
    (pins.pos_open && pins.pos_close) [*4] |=> outs.status[2])
    else $error("bad position not shown");
  // Reset starts in intermediate, so only a drop from a shown state counts
  mid_late_a: assert property (
    $rose(outs.status[3]) && $past(outs.status[2:0]) != 3'h0
    |-> low_len >= TRAV_RST)
    else $error("intermediate shown early");
  mid_shown_a: assert property (
    low_len == TRAV_RST + 32'h8 |-> outs.status[3])
    else $error("intermediate not shown");
  rd_wait_a: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout)
    else $error("read without wait state");
  ready_one_a: assert property (!hreadyout |=> hreadyout)
    else $error("wait state too long");
  // Main scenarios
  cover property ($rose(outs.close_cmd));
  cover property ($rose(outs.status[3]));
  cover property (outs.event_pulse &&
    outs.event_code == swg_pkg::EV_OPEN_FAIL);
endmodule
bind switchgear_object_controller swg_sva #(
  .TRAV_RST(TRAV_RST),
  .PLEN_RST(PLEN_RST)
) u_sva (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .pins(pins),
  .outs(outs)
);
`default_nettype wire

// [bench/breaker_model.sv]
// Purpose: Breaker with open and close position contacts
// Assumes: Contacts leave at T1 and arrive at T2 after a command
// Notes: mode 0 normal, 1 stuck, 2 stalls in transit, 3 welded
`timescale 1ns/1ps
`default_nettype none
module breaker_model #(
  parameter int T1 = 5,
  parameter int T2 = 15
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic [1:0] mode,
  output logic pos_open,
  output logic pos_close
);
  // Position 0 open, 1 closed, 2 in transit
  logic [1:0] pos;
  logic busy, tgt;
  int cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos <= 2'h0;
      busy <= 1'b0;
      tgt <= 1'b0;
      cnt <= 0;
    end else if (!busy && (open_cmd || close_cmd)) begin
      busy <= 1'b1;
      tgt <= close_cmd;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
      // Travel gap shorter than traverse time in normal mode
      if (cnt == T1 && mode != 2'h1) pos <= 2'h2;
      if (cnt >= T2 && mode != 2'h2) begin
        busy <= 1'b0;
        if (mode == 2'h0) pos <= {1'b0, tgt};
      end
    end
  end
  // Welded mode makes both contacts read closed
  assign pos_open = mode == 2'h3 || pos == 2'h0;
  assign pos_close = mode == 2'h3 || pos == 2'h1;
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Purpose: Register and command tests of the object controller
// Assumes: Short traverse, pulse and timeout parameters
// Notes: Refused requests are seen as no command rising
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, seen;
  logic [1:0] htrans, mode, ok, cart;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [3:0] req;
  logic [7:0] blk, sgp, sgl;
  logic m_open, m_close;
  int fail_count, checks;
  swg_pkg::pins_t pins;
  swg_pkg::outs_t outs;
  // Requests: local open, local close, app open, app close
  assign pins = {m_open, m_close, cart, ok, req, blk, sgp, sgl};
  always #2.5 hclk = ~hclk;
  switchgear_object_controller #(
    .TRAV_RST(32'h14),
    .PLEN_RST(32'h32),
    .TMO_RST(32'hc8)
  ) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .pins(pins), .outs(outs)
  );
  breaker_model u_brk (
    .hclk(hclk), .hresetn(hresetn), .open_cmd(outs.open_cmd),
    .close_cmd(outs.close_cmd), .mode(mode), .pos_open(m_open),
    .pos_close(m_close)
  );
  task automatic finish_test();
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // Bounded wait for hready; a hang ends the run
  task automatic bus_wait();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      chk(32'h1, 32'h0);
      finish_test();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    bus_wait();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    bus_wait();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Pulse a request, check acceptance, wait for the move to settle
  task automatic run(input logic [3:0] r, input logic e);
    int n;
    req <= r;
    repeat (6) @(posedge hclk);
    req <= 4'h0;
    seen = outs.open_cmd | outs.close_cmd;
    chk(32'(seen), 32'(e));
    n = 0;
    while ((outs.open_cmd | outs.close_cmd) !== 1'b0 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    if (n == 400) begin
      chk(32'h1, 32'h0);
      finish_test();
    end
    repeat (30) @(posedge hclk);
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, mode, ok, cart, req} = '0;
    {haddr, hwdata, blk, sgp, sgl, fail_count, checks} = '0;
    hsize = 3'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rc(swg_pkg::OFS_CTRL, 32'h0);
    rc(swg_pkg::OFS_MASK, 32'h0);
    rc(swg_pkg::OFS_USED, 32'h1);
    rc(8'h3c, 32'h0);
    wr(swg_pkg::OFS_MASK, 32'hff);
    wr(swg_pkg::OFS_CTRL, 32'h1);
    wr(swg_pkg::OFS_CMD, 32'h2);
    run(4'h0, 1'b0);
    run(4'h4, 1'b1);
    chk(32'(outs.status), 32'h1);
    wr(swg_pkg::OFS_CTRL, 32'h3);
    run(4'h8, 1'b0);
    wr(swg_pkg::OFS_CMD, 32'h1);
    run(4'h0, 1'b1);
    run(4'h1, 1'b1);
    rc(swg_pkg::OFS_NREQ, 32'h0002_0001);
    wr(swg_pkg::OFS_CTRL, 32'hd);
    run(4'h2, 1'b1);
    run(4'h1, 1'b0);
    ok <= 2'b10;
    run(4'h1, 1'b0);
    ok <= 2'b11;
    run(4'h1, 1'b1);
    wr(swg_pkg::OFS_BSEL, 32'h1);
    blk <= 8'h01;
    run(4'h2, 1'b0);
    blk <= 8'h00;
    mode <= 2'h1;
    run(4'h2, 1'b1);
    repeat (200) @(posedge hclk);
    chk(32'(outs.event_code), 32'(swg_pkg::EV_OPEN_FAIL));
    rc(swg_pkg::OFS_NFAIL, 32'h0000_0001);
    mode <= 2'h2;
    run(4'h2, 1'b1);
    chk(32'(outs.status), 32'h8);
    mode <= 2'h0;
    repeat (30) @(posedge hclk);
    mode <= 2'h3;
    repeat (8) @(posedge hclk);
    chk(32'(outs.status[2]), 32'h1);
    mode <= 2'h0;
    cart <= 2'b11;
    wr(swg_pkg::OFS_CTRL, 32'h1d);
    repeat (4) @(posedge hclk);
    chk(32'(outs.status), 32'h4);
    cart <= 2'b00;
    repeat (8) @(posedge hclk);
    wr(swg_pkg::OFS_CMD, 32'h4);
    rc(swg_pkg::OFS_NREQ, 32'h0);
    rc(swg_pkg::OFS_NFAIL, 32'h0);
    wr(swg_pkg::OFS_CTRL, 32'h101);
    run(4'h1, 1'b1);
    run(4'h2, 1'b1);
    chk(32'(outs.status), 32'h3);
    wr(swg_pkg::OFS_CMD, 32'h10);
    repeat (2) @(posedge hclk);
    chk(32'(outs.status), 32'h2);
    wr(swg_pkg::OFS_LSEL, 32'h0);
    xfer(1'b0, swg_pkg::OFS_LDATA, 32'h0);
    chk(32'(q[15:14]), 32'h0);
    xfer(1'b0, swg_pkg::OFS_STAT, 32'h0);
    chk(32'(q[15:12]), 32'h9);
    wr(swg_pkg::OFS_CMD, 32'h8);
    xfer(1'b0, swg_pkg::OFS_STAT, 32'h0);
    chk(32'(q[15:12]), 32'h0);
    wr(swg_pkg::OFS_USED, 32'h0c);
    wr(swg_pkg::OFS_CTRL, 32'h80);
    sgl <= 8'h04;
    sgp <= 8'h08;
    repeat (6) @(posedge hclk);
    {sgp, sgl} <= '0;
    repeat (4) @(posedge hclk);
    chk(32'(outs.active_sg), 32'h2);
    sgp <= 8'h01;
    repeat (6) @(posedge hclk);
    sgp <= 8'h00;
    chk(32'(outs.active_sg), 32'h2);
    wr(swg_pkg::OFS_CMD, 32'h340);
    repeat (4) @(posedge hclk);
    chk(32'(outs.active_sg), 32'h2);
    wr(swg_pkg::OFS_CTRL, 32'ha0);
    wr(swg_pkg::OFS_CMD, 32'h340);
    repeat (4) @(posedge hclk);
    chk(32'(outs.active_sg), 32'h3);
    wr(swg_pkg::OFS_CMD, 32'h220);
    repeat (4) @(posedge hclk);
    chk(32'(outs.active_sg), 32'h3);
    wr(swg_pkg::OFS_CTRL, 32'hc0);
    wr(swg_pkg::OFS_CMD, 32'h220);
    repeat (4) @(posedge hclk);
    chk(32'(outs.active_sg), 32'h2);
    finish_test();
  end
endmodule
`default_nettype wire
